// File: core/odr_pkg.sv
// constants and codes for the on-demand dma request port
//==============================================================
// What this block does
// - release and strobe pins act only while the on-demand mode bit is one
// - release request with transfer strobe together queues a channel 2 request
// - an accepted release request raises the bus-released notice
// - data lines stop being driven two cycles after the notice
// - strobe alone repeats the last channel, not right after a notice
// - reply strobe with read data, two cycles ahead of write data
// - channel number codes 00 to 11 sit in word bits 59 and 58
// - request word is 64 bits, bits 47 to 32 are ignored
// - size code in bits 63 to 61 selects size, clear or end
// - bit 60 picks read or write, address goes to source or destination
// - request mode bits 57 and 56 pick handshake, burst or cycle steal
// - eight-bit count, zero means the maximum of 16M transfers
// - for channels 1 to 3 only the channel number is used
// - count field ignored when request mode is 00
// - edge burst runs continuously, level burst and cycle steal handshake
// - channel 0 end word stops transfer and leaves the end flag unchanged
// - channel 0 setup word loads fixed control, count and address
// - software may write channel 0 registers, later setup word overwrites
// - after a channel 0 setup or handshake word, refuse requests until transfer completes
// - four-deep queues for channels 1 to 3 drop requests when full
// - channel 0 word with mode 00 and a size code other than prohibited or clear raises a handshake request
package odr_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_CH0_CTRL = 8'h08;
    localparam logic [7:0] ADDR_CH0_SRC = 8'h0c;
    localparam logic [7:0] ADDR_CH0_DST = 8'h10;
    localparam logic [7:0] ADDR_CH0_TALLY = 8'h14;
    // control register bits
    localparam int CTRL_ODM_BIT = 0;
    localparam int CTRL_PFE_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    // channel0_control field positions
    localparam int CC_EN = 0;
    localparam int CC_DONE_FLAG = 1;
    localparam int CC_END_IRQ = 2;
    localparam int CC_UNIT_SIZE = 4;
    localparam int CC_STYLE = 7;
    localparam int CC_REQ_SRC = 8;
    localparam int CC_SRC_STEP = 12;
    localparam int CC_DST_STEP = 14;
    localparam int CC_ACK_LEVEL = 16;
    localparam int CC_REQ_LEVEL = 17;
    localparam int CC_REQ_SENSE = 18;
    localparam logic [31:0] CH0_CTRL_RESET = 32'h0;
    // request word fields
    localparam int W_SIZE = 61;
    localparam int W_RW = 60;
    localparam int W_ID = 58;
    localparam int W_MODE = 56;
    localparam int W_CNT = 48;
    // codes
    localparam logic [2:0] SIZE_PROHIB = 3'h5;
    localparam logic [2:0] SIZE_CLEAR = 3'h6;
    localparam logic [2:0] SIZE_END = 3'h7;
    localparam logic [1:0] MODE_HANDSHAKE = 2'h0;
    localparam logic [1:0] MODE_EDGE_BURST = 2'h1;
    localparam logic [1:0] MODE_STEAL = 2'h3;
    localparam logic [3:0] SRC_READ = 4'h2;
    localparam logic [3:0] SRC_WRITE = 4'h3;
    localparam logic [1:0] STEP_FIXED = 2'h1;
    localparam logic [2:0] QUEUE_DEPTH = 3'h4;
    localparam logic [1:0] CHAN_DIRECT = 2'h2;
    // notice to word spacing, in cycles
    localparam int RELEASE_GAP = 2;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_NOTICE = 4'b0010,
        ST_GAP = 4'b0100,
        ST_WORD = 4'b1000
    } odr_state_t;
endpackage

// File: core/odr_port.sv
// on-demand dma request port with axi4-lite register slave
`timescale 1ns/1ps
`default_nettype none
module odr_port import odr_pkg::*; (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // axi4-lite slave
    input wire logic [7:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [7:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    // external device pins, strobes active low
    input wire logic i_bus_release_request_n,
    input wire logic i_transfer_request_strobe_n,
    output logic o_bus_released_notice_n,
    output logic o_transfer_reply_strobe_n,
    input wire logic [63:0] i_data,
    output logic [63:0] o_data,
    output logic o_data_oe,
    // dma channel side
    input wire logic i_read_beat,
    input wire logic i_write_beat,
    input wire logic [63:0] i_write_data,
    input wire logic i_ch0_done,
    input wire logic [2:0] i_queue_take,
    output logic o_ch0_request,
    output logic [2:0] o_queue_pending,
    output logic [1:0] o_channel_number,
    output logic o_burst_continuous
);
    //==============================================================
    // register state
    logic [1:0] ctrl_q;
    logic [31:0] ch0_ctrl_q;
    logic [31:0] ch0_src_q;
    logic [31:0] ch0_dst_q;
    logic [31:0] ch0_tally_q;
    logic ch0_busy_q;
    logic ch0_req_q;
    logic last_valid_q;
    logic [1:0] last_ch_q;
    logic [2:0] qcnt_q [3];
    odr_state_t state_q;
    logic [63:0] wd1_q;
    logic wv1_q;
    logic [63:0] data_q;
    logic oe_q;

    function automatic logic reg_hit(input logic [7:0] a);
        reg_hit = (a == ADDR_CTRL) || (a == ADDR_STAT) || (a == ADDR_CH0_CTRL) ||
            (a == ADDR_CH0_SRC) || (a == ADDR_CH0_DST) || (a == ADDR_CH0_TALLY);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        for (int i = 0; i < 4; i++) begin
            merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction

    //==============================================================
    // axi4-lite write path
    logic aw_held_q;
    logic w_held_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic wr_fire;

    assign o_awready = !aw_held_q && !bvalid_q;
    assign o_wready = !w_held_q && !bvalid_q;
    assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
    assign o_bvalid = bvalid_q;
    assign o_bresp = bresp_q;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= 8'h0;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'h0;
        end else begin
            if (i_awvalid && o_awready) begin
                aw_held_q <= 1'b1;
                awaddr_q <= i_awaddr;
            end
            if (i_wvalid && o_wready) begin
                w_held_q <= 1'b1;
                wdata_q <= i_wdata;
                wstrb_q <= i_wstrb;
            end
            if (wr_fire) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= reg_hit(awaddr_q) && (awaddr_q != ADDR_STAT) ? 2'h0 : 2'h2;
            end else if (bvalid_q && i_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    //==============================================================
    // axi4-lite read path
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic [31:0] stat_w;

    assign stat_w = {18'h0, last_valid_q, last_ch_q, ch0_req_q, ch0_busy_q,
        qcnt_q[2], qcnt_q[1], qcnt_q[0]};
    assign o_arready = !rvalid_q;
    assign o_rvalid = rvalid_q;
    assign o_rdata = rdata_q;
    assign o_rresp = rresp_q;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= 2'h0;
        end else if (i_arvalid && o_arready) begin
            rvalid_q <= 1'b1;
            rresp_q <= reg_hit(i_araddr) ? 2'h0 : 2'h2;
            if (i_araddr == ADDR_CTRL) begin
                rdata_q <= {30'h0, ctrl_q};
            end else if (i_araddr == ADDR_STAT) begin
                rdata_q <= stat_w;
            end else if (i_araddr == ADDR_CH0_CTRL) begin
                rdata_q <= ch0_ctrl_q;
            end else if (i_araddr == ADDR_CH0_SRC) begin
                rdata_q <= ch0_src_q;
            end else if (i_araddr == ADDR_CH0_DST) begin
                rdata_q <= ch0_dst_q;
            end else if (i_araddr == ADDR_CH0_TALLY) begin
                rdata_q <= ch0_tally_q;
            end else begin
                rdata_q <= 32'h0;
            end
        end else if (rvalid_q && i_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ctrl_q <= CTRL_RESET;
        end else if (wr_fire && awaddr_q == ADDR_CTRL && wstrb_q[0]) begin
            ctrl_q <= wdata_q[1:0];
        end
    end

    //==============================================================
    // pin front end
    logic odm;
    logic rel_req;
    logic strobe;
    logic direct;
    logic word_in;
    logic repeat_in;
    logic [2:0] w_size;
    logic [1:0] w_id;
    logic [1:0] w_mode;
    logic ch0_word;
    logic push_any;
    logic [1:0] push_ch;
    logic do_clear;
    logic do_end;
    logic do_setup;
    logic do_hs;

    assign odm = ctrl_q[CTRL_ODM_BIT];
    assign rel_req = odm && !i_bus_release_request_n;
    assign strobe = odm && !i_transfer_request_strobe_n;
    // direct request never arbitrates the bus, so no notice follows it
    assign direct = rel_req && strobe && state_q == ST_IDLE && !ch0_busy_q;
    assign word_in = state_q == ST_WORD && strobe && !ch0_busy_q;
    // strobe alone two cycles after a notice is a word, never a repeat
    assign repeat_in = state_q == ST_IDLE && strobe && !rel_req && last_valid_q && !ch0_busy_q;
    // bits 47 to 32 are never looked at
    assign w_size = i_data[W_SIZE +: 3];
    assign w_id = i_data[W_ID +: 2];
    assign w_mode = i_data[W_MODE +: 2];
    assign ch0_word = word_in && w_id == 2'h0;
    assign do_hs = ch0_word && w_mode == MODE_HANDSHAKE && w_size != SIZE_PROHIB && w_size != SIZE_CLEAR;
    assign do_end = ch0_word && w_mode != MODE_HANDSHAKE && w_size == SIZE_END;
    assign do_clear = ch0_word && w_mode != MODE_HANDSHAKE && w_size == SIZE_CLEAR;
    assign do_setup = ch0_word && w_mode != MODE_HANDSHAKE && !do_end && !do_clear;

    always_comb begin
        push_any = 1'b0;
        push_ch = 2'h0;
        if (direct) begin
            push_any = 1'b1;
            push_ch = CHAN_DIRECT;
        end else if (word_in && w_id != 2'h0) begin
            // only the channel number matters here
            push_any = 1'b1;
            push_ch = w_id;
        end else if (repeat_in && last_ch_q != 2'h0) begin
            push_any = 1'b1;
            push_ch = last_ch_q;
        end
    end

    //==============================================================
    // bus release sequence
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (rel_req && !strobe) begin
                        state_q <= ST_NOTICE;
                    end
                end
                ST_NOTICE: begin
                    state_q <= ST_GAP;
                end
                ST_GAP: begin
                    state_q <= ST_WORD;
                end
                ST_WORD: begin
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    assign o_bus_released_notice_n = state_q != ST_NOTICE;

    //==============================================================
    // last channel memory and channel 0 request
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            last_valid_q <= 1'b0;
            last_ch_q <= 2'h0;
        end else if (direct) begin
            last_valid_q <= 1'b1;
            last_ch_q <= CHAN_DIRECT;
        end else if (word_in && (w_id != 2'h0 || do_hs)) begin
            last_valid_q <= 1'b1;
            last_ch_q <= w_id;
        end
    end

    assign o_channel_number = last_ch_q;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ch0_req_q <= 1'b0;
        end else if (do_clear) begin
            ch0_req_q <= 1'b0;
        end else begin
            ch0_req_q <= do_hs || (repeat_in && last_ch_q == 2'h0);
        end
    end

    assign o_ch0_request = ch0_req_q;

    // busy from a channel 0 setup or handshake word until the channel reports completion
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ch0_busy_q <= 1'b0;
        end else if (do_setup || do_hs) begin
            ch0_busy_q <= 1'b1;
        end else if (i_ch0_done || do_end || do_clear) begin
            ch0_busy_q <= 1'b0;
        end
    end

    //==============================================================
    // request queues for channels 1 to 3
    for (genvar c = 0; c < 3; c++) begin : g_queue
        logic push_c;
        logic pop_c;
        assign push_c = push_any && push_ch == 2'(c + 1) && qcnt_q[c] != QUEUE_DEPTH;
        assign pop_c = i_queue_take[c] && qcnt_q[c] != 3'h0;
        always_ff @(posedge i_clk or posedge i_rst) begin
            if (i_rst) begin
                qcnt_q[c] <= 3'h0;
            end else if (do_clear) begin
                qcnt_q[c] <= 3'h0;
            end else if (push_c && !pop_c) begin
                qcnt_q[c] <= qcnt_q[c] + 3'h1;
            end else if (pop_c && !push_c) begin
                qcnt_q[c] <= qcnt_q[c] - 3'h1;
            end
        end
        assign o_queue_pending[c] = qcnt_q[c] != 3'h0;
    end

    //==============================================================
    // channel 0 registers
    logic [31:0] setup_ctrl;
    always_comb begin
        setup_ctrl = CH0_CTRL_RESET;
        setup_ctrl[CC_EN] = 1'b1;
        setup_ctrl[CC_END_IRQ] = 1'b0;
        setup_ctrl[CC_UNIT_SIZE +: 3] = w_size;
        setup_ctrl[CC_STYLE] = w_mode != MODE_STEAL;
        setup_ctrl[CC_REQ_SRC +: 4] = i_data[W_RW] ? SRC_WRITE : SRC_READ;
        setup_ctrl[CC_SRC_STEP +: 2] = STEP_FIXED;
        setup_ctrl[CC_DST_STEP +: 2] = STEP_FIXED;
        setup_ctrl[CC_ACK_LEVEL] = 1'b0;
        setup_ctrl[CC_REQ_LEVEL] = 1'b0;
        setup_ctrl[CC_REQ_SENSE] = w_mode == MODE_EDGE_BURST;
    end

    // a setup word wins over a software write in the same cycle
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ch0_ctrl_q <= CH0_CTRL_RESET;
        end else if (do_setup) begin
            ch0_ctrl_q <= setup_ctrl;
        end else begin
            if (wr_fire && awaddr_q == ADDR_CH0_CTRL) begin
                ch0_ctrl_q <= merge(ch0_ctrl_q, wdata_q, wstrb_q);
            end
            if (do_end) begin
                ch0_ctrl_q[CC_EN] <= 1'b0;
            end
            if (i_ch0_done) begin
                ch0_ctrl_q[CC_DONE_FLAG] <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ch0_src_q <= 32'h0;
            ch0_dst_q <= 32'h0;
            ch0_tally_q <= 32'h0;
        end else if (do_setup) begin
            // tally of zero stands for the full 16M count
            // mode 00 words never reach here, so their count is ignored
            ch0_tally_q <= {24'h0, i_data[W_CNT +: 8]};
            if (i_data[W_RW]) begin
                ch0_dst_q <= i_data[31:0];
            end else begin
                ch0_src_q <= i_data[31:0];
            end
        end else if (wr_fire) begin
            if (awaddr_q == ADDR_CH0_SRC) begin
                ch0_src_q <= merge(ch0_src_q, wdata_q, wstrb_q);
            end else if (awaddr_q == ADDR_CH0_DST) begin
                ch0_dst_q <= merge(ch0_dst_q, wdata_q, wstrb_q);
            end else if (awaddr_q == ADDR_CH0_TALLY) begin
                ch0_tally_q <= merge(ch0_tally_q, wdata_q, wstrb_q);
            end
        end
    end

    assign o_burst_continuous = ch0_ctrl_q[CC_STYLE] && ch0_ctrl_q[CC_REQ_SENSE];

    //==============================================================
    // reply strobe and write data pipe
    assign o_transfer_reply_strobe_n = !(i_read_beat || i_write_beat);

    // write data trails its strobe by two cycles; a beat landing in the word slot is dropped
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wd1_q <= 64'h0;
            wv1_q <= 1'b0;
            data_q <= 64'h0;
            oe_q <= 1'b0;
        end else begin
            wd1_q <= i_write_data;
            wv1_q <= i_write_beat;
            data_q <= wd1_q;
            oe_q <= wv1_q && state_q != ST_GAP;
        end
    end

    assign o_data = data_q;
    assign o_data_oe = oe_q;

    //==============================================================
    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    property p_notice;
        (ctrl_q[CTRL_ODM_BIT] && !i_bus_release_request_n && i_transfer_request_strobe_n && state_q == ST_IDLE)
            |=> !o_bus_released_notice_n ##1 o_bus_released_notice_n;
    endproperty
    a_notice: assert property (p_notice) else $error("notice not one cycle after release request");

    property p_release;
        !o_bus_released_notice_n |-> ##2 !o_data_oe;
    endproperty
    a_release: assert property (p_release) else $error("data driven two cycles after notice");

    property p_gated;
        !ctrl_q[CTRL_ODM_BIT] |=> $stable(state_q) or state_q != ST_NOTICE;
    endproperty
    a_gated: assert property (p_gated) else $error("release sequence started with mode off");

    property p_direct;
        (direct && qcnt_q[1] == 3'h0 && i_queue_take[1] == 1'b0) |=> qcnt_q[1] == 3'h1 && o_bus_released_notice_n;
    endproperty
    a_direct: assert property (p_direct) else $error("direct request not queued on channel 2");

    property p_full;
        (qcnt_q[0] == QUEUE_DEPTH && !i_queue_take[0] && !do_clear) |=> qcnt_q[0] == QUEUE_DEPTH;
    endproperty
    a_full: assert property (p_full) else $error("full queue changed without a take");

    property p_wdata;
        (i_write_beat && state_q == ST_IDLE && !rel_req) |-> ##2 o_data_oe;
    endproperty
    a_wdata: assert property (p_wdata) else $error("write data not two cycles after reply");

    property p_busy;
        (ch0_busy_q && !i_ch0_done && !wr_fire) |=> !$rose(o_ch0_request) && $stable(ch0_src_q);
    endproperty
    a_busy: assert property (p_busy) else $error("request taken while channel 0 busy");

    property p_end;
        do_end |=> !ch0_ctrl_q[CC_EN] && $stable(ch0_ctrl_q[CC_DONE_FLAG]);
    endproperty
    a_end: assert property (p_end) else $error("end word did not stop channel 0");

    property p_setup;
        (do_setup && !i_data[W_RW]) |=> ch0_ctrl_q[CC_REQ_SRC +: 4] == SRC_READ && ch0_ctrl_q[CC_END_IRQ] == 1'b0;
    endproperty
    a_setup: assert property (p_setup) else $error("setup word loaded wrong control");
endmodule
`default_nettype wire

// File: dv/odr_far_dev.sv
// far-end requester model for the request port
`timescale 1ns/1ps
`default_nettype none
//==================
// requester
module odr_far_dev (
    input wire logic i_clk,
    input wire logic i_notice_n,
    input wire logic i_oe,
    output logic o_rel_n,
    output logic o_stb_n,
    output logic [63:0] o_data
);
    initial begin
        o_rel_n = 1'b1;
        o_stb_n = 1'b1;
        o_data = 64'h0;
    end
    // word only after a notice, two cycles on
    task automatic send(input logic [63:0] w, output logic ok);
        @(posedge i_clk) o_rel_n <= 1'b0;
        @(posedge i_clk) o_rel_n <= 1'b1;
        #1 ok = (i_notice_n === 1'b0);
        @(posedge i_clk);
        #1 ok &= (i_notice_n === 1'b1);
        if (ok) begin
            @(posedge i_clk) begin
                o_stb_n <= 1'b0;
                o_data <= w;
            end
            #1 ok &= (i_oe === 1'b0);
            @(posedge i_clk) begin
                o_stb_n <= 1'b1;
                o_data <= ~w;
            end
        end
    endtask
    // release and strobe together
    task automatic direct(output logic ok);
        @(posedge i_clk) begin
            o_rel_n <= 1'b0;
            o_stb_n <= 1'b0;
        end
        @(posedge i_clk) begin
            o_rel_n <= 1'b1;
            o_stb_n <= 1'b1;
        end
        #1 ok = (i_notice_n === 1'b1);
    endtask
    // strobe alone, never two cycles after a notice
    task automatic again;
        @(posedge i_clk) o_stb_n <= 1'b0;
        @(posedge i_clk) o_stb_n <= 1'b1;
    endtask
endmodule
`default_nettype wire

// File: dv/odr_port_tb.sv
// self-checking bench for the request port
`timescale 1ns/1ps
`default_nettype none
//==================
// bench
module odr_port_tb import odr_pkg::*;;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [7:0] i_awaddr = 8'h0, i_araddr = 8'h0;
    logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
    logic [31:0] i_wdata = 32'h0;
    logic i_read_beat = 1'b0, i_write_beat = 1'b0, i_ch0_done = 1'b0;
    logic [63:0] i_write_data = 64'h0;
    logic rel_n, stb_n, notice_n, reply_n, oe, o_ch0_request, o_bvalid, o_rvalid, o_awready, o_wready, o_arready;
    logic [63:0] dat, o_data;
    logic [31:0] o_rdata;
    logic [1:0] o_rresp, o_channel_number, o_bresp;
    logic [2:0] o_queue_pending, i_queue_take = 3'h0;
    logic o_burst_continuous;
    int bad_count = 0, tests_run = 0;
    always #5 i_clk = ~i_clk;
    odr_far_dev far_u (.i_clk, .i_notice_n(notice_n), .i_oe(oe), .o_rel_n(rel_n), .o_stb_n(stb_n), .o_data(dat));
    odr_port dut_u (.i_clk, .i_rst, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb(4'hf), .i_wvalid,
        .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp,
        .o_rvalid, .i_rready, .i_bus_release_request_n(rel_n), .i_transfer_request_strobe_n(stb_n),
        .o_bus_released_notice_n(notice_n), .o_transfer_reply_strobe_n(reply_n), .i_data(dat), .o_data,
        .o_data_oe(oe), .i_read_beat, .i_write_beat, .i_write_data, .i_ch0_done, .i_queue_take,
        .o_ch0_request, .o_queue_pending, .o_channel_number, .o_burst_continuous);
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic test_done;
        $display("compares %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk) begin
            i_awaddr <= a;
            i_wdata <= d;
            i_awvalid <= 1'b1;
            i_wvalid <= 1'b1;
            i_bready <= 1'b1;
        end
        do begin
            @(posedge i_clk);
            if (o_awready)
                i_awvalid <= 1'b0;
            if (o_wready)
                i_wvalid <= 1'b0;
        end while (!o_bvalid);
        chk(64'(o_bresp), 64'h0);
        i_bready <= 1'b0;
    endtask
    // read, mask, compare data and response
    task automatic rck(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] r);
        @(posedge i_clk) begin
            i_araddr <= a;
            i_arvalid <= 1'b1;
            i_rready <= 1'b1;
        end
        do begin
            @(posedge i_clk);
            if (o_arready)
                i_arvalid <= 1'b0;
        end while (!o_rvalid);
        chk(64'(o_rdata & m), 64'(e));
        chk(64'(o_rresp), 64'(r));
        i_rready <= 1'b0;
    endtask
    // junk in bits 47..32 must not matter
    function automatic logic [63:0] wd(input logic [2:0] size_c, input logic [1:0] chan, input logic [1:0] mode);
        return {size_c, 1'b0, chan, mode, 8'h10, 16'hbeef, 32'h1000_0040};
    endfunction
    task automatic t_regs;
        logic ok;
        far_u.send(wd(3'h3, 2'h1, 2'h1), ok);
        chk(64'(ok), 64'h0);
        axw(ADDR_CTRL, 32'h1);
        rck(ADDR_CTRL, 32'h1, 32'h3, 2'h0);
        rck(8'h3c, 32'h0, 32'hffff_ffff, 2'h2);
        $display("regs done");
    endtask
    task automatic t_ch0;
        logic ok;
        axw(ADDR_CH0_SRC, 32'h5);
        far_u.send(wd(3'h3, 2'h0, 2'h1), ok);
        chk(64'(ok), 64'h1);
        rck(ADDR_CH0_CTRL, 32'h452b0, 32'hffff_fffe, 2'h0);
        rck(ADDR_CH0_SRC, 32'h1000_0040, 32'hffff_ffff, 2'h0);
        rck(ADDR_CH0_TALLY, 32'h10, 32'hffff_ffff, 2'h0);
        chk(64'(o_burst_continuous), 64'h1);
        far_u.send(wd(3'h0, 2'h1, 2'h0), ok);
        rck(ADDR_STAT, 32'h200, 32'h207, 2'h0);
        @(posedge i_clk) i_ch0_done <= 1'b1;
        @(posedge i_clk) i_ch0_done <= 1'b0;
        rck(ADDR_STAT, 32'h0, 32'h200, 2'h0);
        axw(ADDR_CH0_CTRL, 32'h1);
        far_u.send(wd(3'h7, 2'h0, 2'h1), ok);
        rck(ADDR_CH0_CTRL, 32'h0, 32'h3, 2'h0);
        $display("ch0 done");
    endtask
    task automatic t_q;
        logic ok;
        repeat (5) far_u.send(wd(3'h7, 2'h1, 2'h0), ok);
        rck(ADDR_STAT, 32'h4, 32'h7, 2'h0);
        @(posedge i_clk) i_queue_take <= 3'h1;
        @(posedge i_clk) i_queue_take <= 3'h0;
        rck(ADDR_STAT, 32'h3, 32'h7, 2'h0);
        chk(64'(o_queue_pending), 64'h1);
        far_u.send(wd(3'h0, 2'h3, 2'h3), ok);
        far_u.again();
        rck(ADDR_STAT, 32'h80, 32'h1c0, 2'h0);
        chk(64'(o_channel_number), 64'h3);
        far_u.direct(ok);
        chk(64'(ok), 64'h1);
        rck(ADDR_STAT, 32'h8, 32'h38, 2'h0);
        far_u.send(wd(3'h6, 2'h0, 2'h2), ok);
        rck(ADDR_STAT, 32'h0, 32'h3ff, 2'h0);
        chk(64'(o_queue_pending), 64'h0);
        $display("queues done");
    endtask
    task automatic t_io;
        logic ok;
        axw(ADDR_CTRL, 32'h3);
        far_u.send(wd(3'h3, 2'h0, 2'h0), ok);
        #1 chk(64'(o_ch0_request), 64'h1);
        @(posedge i_clk) i_read_beat <= 1'b1;
        #1 chk(64'(reply_n), 64'h0);
        @(posedge i_clk) begin
            i_read_beat <= 1'b0;
            i_write_beat <= 1'b1;
            i_write_data <= 64'h0123_4567_89ab_cdef;
        end
        @(posedge i_clk) i_write_beat <= 1'b0;
        @(posedge i_clk);
        #1 chk(o_data, 64'h0123_4567_89ab_cdef);
        chk(64'(oe), 64'h1);
        $display("io done");
    endtask
    initial begin
        repeat (8) @(posedge i_clk);
        i_rst <= 1'b0;
        t_regs();
        t_ch0();
        t_q();
        t_io();
        test_done();
    end
    initial begin
        #100000;
        bad_count++;
        test_done();
    end
endmodule
`default_nettype wire
